// ===== ecppt_pkg.sv
// Purpose: Shared constants and types for the ECP parallel port engine.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes: Register indices are kept as printed; byte address is index * 4.
package ecppt_pkg;

  // ***************************************************
  // Register map
  // ***************************************************
  localparam logic [15:0] IDX_DATA = 16'h0000;
  localparam logic [15:0] IDX_STATUS = 16'h0001;
  localparam logic [15:0] IDX_CONTROL = 16'h0002;
  localparam logic [15:0] IDX_FIFO = 16'h0400;
  localparam logic [15:0] IDX_CFGB = 16'h0401;
  localparam logic [15:0] IDX_EXTCTRL = 16'h0402;
  localparam logic [15:0] IDX_LOCAL = 16'h0403;
  localparam logic [15:0] ADDR_DATA = {IDX_DATA[13:0], 2'b00};
  localparam logic [15:0] ADDR_STATUS = {IDX_STATUS[13:0], 2'b00};
  localparam logic [15:0] ADDR_CONTROL = {IDX_CONTROL[13:0], 2'b00};
  localparam logic [15:0] ADDR_FIFO = {IDX_FIFO[13:0], 2'b00};
  localparam logic [15:0] ADDR_CFGB = {IDX_CFGB[13:0], 2'b00};
  localparam logic [15:0] ADDR_EXTCTRL = {IDX_EXTCTRL[13:0], 2'b00};
  localparam logic [15:0] ADDR_LOCAL = {IDX_LOCAL[13:0], 2'b00};

  // ***************************************************
  // Modes and fields
  // ***************************************************
  localparam logic [2:0] MODE_STD = 3'h0;
  localparam logic [2:0] MODE_BIDIR = 3'h1;
  localparam logic [2:0] MODE_FIFO = 3'h2;
  localparam logic [2:0] MODE_ECP = 3'h3;
  localparam logic [2:0] MODE_EPP = 3'h4;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CONFIG = 3'h7;
  localparam int ECR_MODE_LSB = 5;
  localparam int ECR_NERR = 4;
  localparam int ECR_DMA_ENABLE_BIT = 3;
  localparam int ECR_SVC = 2;
  localparam int LOCAL_SINGLE_FLOPPY_EXTENSION_MODE = 4;
  localparam logic [7:0] CFGA_VALUE = 8'h10;
  localparam logic [5:0] CFGB_LOW = 6'h3f;
  localparam logic [2:0] STATUS_LOW = 3'h7;
  localparam logic [1:0] CONTROL_HIGH = 2'h3;
  localparam logic [3:0] THRESH_RESET = 4'h8;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam int FIFO_AW = 4;

  typedef struct packed {
    logic cmd;
    logic [7:0] data;
  } ecppt_entry_t;

  typedef struct packed {
    logic dir;
    logic ackIntEn;
    logic selectIn;
    logic init;
    logic autoFd;
    logic strobe;
  } ecppt_ctrl_t;

  typedef struct packed {
    logic [7:0] pdOut;
    logic pdOe;
    logic strobeN;
    logic autoFdN;
    logic initN;
    logic selectInN;
  } ecppt_pins_t;

  localparam ecppt_ctrl_t CTRL_RESET = '0;

endpackage

// ===== ecppt_port.sv
// Purpose: ECP parallel port transfer engine with shared FIFO and APB.
// Assumes: All pin inputs are synchronous to clk.
// Notes: Summary of operation follows.
// Summary of operation
// - Forward strobes latch bytes into the peripheral, paced by Busy.
// - Reverse bytes are requested with nAutoFd and delivered with nAck.
// - Forward HostAck high sends data, low sends a command byte.
// - Reverse PeriphAck high marks data, low marks a command byte.
// - Data lines are driven only while nAckReverse permits forward.
// - Falling nFault raises an error interrupt in forward ECP mode.
// - nReverseRequest is driven low for reverse, high for forward.
// - nSelectIn stays deasserted throughout ECP mode.
// - Address port writes go out as commands, data port as data.
// - Automatic handshaking runs only in FIFO and ECP modes.
// - Leaving a non-basic mode is allowed only back to modes 0 or 1.
// - Direction may change only in bidirectional mode.
// - Repeat count goes to the address port, byte to the data port.
// - FIFO is off after reset, uses a set threshold, FIFO modes only.
// - DMA moves only FIFO port data, requested by the request line.
// - DMA terminal count sets the service flag and stops DMA.
// - PIO uses the FIFO ports after software sets up the flags.
// - In PIO the interrupt line asks the host to service the FIFO.
// - Floppy extension mode forces drive B motor and select inactive.
// - Floppy extension mode ORs data pins PD4-PD0 into floppy inputs.
// - Mode codes as listed; the FIFO is held reset in standard mode.
// - All FIFO ports share one sixteen byte buffer.
// - The service flag is sticky until software writes it to zero.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
module ecppt_port
  import ecppt_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pdIn,
  input wire logic busy,
  input wire logic ackN,
  input wire logic pError,
  input wire logic select,
  input wire logic faultN,
  output ecppt_pins_t pins,
  output logic dmaReq,
  input wire logic dmaAck,
  input wire logic dmaTc,
  input wire logic [7:0] dmaWrData,
  output logic [7:0] dmaRdData,
  output logic irqOut,
  input wire logic fdcMotorBN,
  input wire logic fdcSelectBN,
  input wire logic diskChangeInN,
  input wire logic readDataInN,
  input wire logic writeProtectInN,
  input wire logic trackZeroInN,
  input wire logic indexInN,
  output logic driveBMotorOutN,
  output logic driveBSelectOutN,
  output logic [4:0] fdcInN
);

  // ***************************************************
  // Declarations
  // ***************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_RV_REQ, ST_RV_DONE
  } ecppt_state_t;

  ecppt_state_t st;
  ecppt_ctrl_t ctrl;
  ecppt_entry_t mem [FIFO_DEPTH];
  ecppt_entry_t head;
  ecppt_entry_t pushEntry;
  logic [2:0] mode;
  logic nErrIntrEn;
  logic dma_enable_bit;
  logic service_interrupt_flag;
  logic [3:0] thresh;
  logic single_floppy_extension_mode;
  logic [7:0] dataReg;
  logic [7:0] pdReg;
  logic cmdReg;
  logic faultPrev;
  logic [FIFO_AW-1:0] wrPtr;
  logic [FIFO_AW-1:0] rdPtr;
  logic [4:0] count;
  logic [4:0] freeSlots;
  logic full;
  logic empty;
  logic acc;
  logic wrOk;
  logic isData, isStatus, isCtrl, isFifo, isCfgb, isExt, isLocal;
  logic mapped;
  logic [7:0] rdByte;
  logic fifoMode;
  logic fwdAuto;
  logic revAuto;
  logic fwdGo;
  logic hostPush, hostPop, dmaPush, dmaPop, engPush, engPop;
  logic push, pop;
  logic ecrWr;
  logic [2:0] newMode;
  logic modeLegal;
  logic svcCond;
  logic svcSet;
  logic faultEvt;

  // ***************************************************
  // Register bus decode
  // ***************************************************
  always_comb begin
    isData = paddr == ADDR_DATA;
    isStatus = paddr == ADDR_STATUS;
    isCtrl = paddr == ADDR_CONTROL;
    isFifo = paddr == ADDR_FIFO;
    isCfgb = paddr == ADDR_CFGB;
    isExt = paddr == ADDR_EXTCTRL;
    isLocal = paddr == ADDR_LOCAL;
    mapped = isData | isStatus | isCtrl | isFifo | isExt | isLocal |
             (isCfgb & (mode == MODE_CONFIG));
    rdByte = 8'h00;
    if (isData) begin
      rdByte = (mode == MODE_BIDIR) ? pdIn : dataReg;
    end else if (isStatus) begin
      rdByte = {~busy, ackN, pError, select, faultN, STATUS_LOW};
    end else if (isCtrl) begin
      rdByte = {CONTROL_HIGH, ctrl};
    end else if (isFifo) begin
      rdByte = (mode == MODE_CONFIG) ? CFGA_VALUE : head.data;
    end else if (isCfgb) begin
      rdByte = {1'b0, irqOut, CFGB_LOW};
    end else if (isExt) begin
      rdByte = {mode, nErrIntrEn, dma_enable_bit, service_interrupt_flag, full, empty};
    end else if (isLocal) begin
      rdByte = {3'h0, single_floppy_extension_mode, thresh};
    end
  end

  assign acc = psel & penable;
  assign pready = acc;
  assign wrOk = acc & pwrite & pstrb[0] & mapped;
  assign ecrWr = wrOk & isExt;
  assign newMode = pwdata[ECR_MODE_LSB +: 3];
  // Leaving an extended mode must pass through a basic mode first.
  assign modeLegal = (mode == MODE_STD) | (mode == MODE_BIDIR) |
                     (newMode == MODE_STD) | (newMode == MODE_BIDIR);

  // Read data is captured in the setup cycle so the access phase is
  // zero wait and the FIFO head is sampled before the pop.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      prdata <= {24'h0, rdByte};
      pslverr <= ~mapped;
    end
  end

  // ***************************************************
  // Control registers
  // ***************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= MODE_STD;
      nErrIntrEn <= 1'b0;
      dma_enable_bit <= 1'b0;
    end else if (ecrWr) begin
      if (modeLegal) begin
        mode <= newMode;
      end
      nErrIntrEn <= pwdata[ECR_NERR];
      dma_enable_bit <= pwdata[ECR_DMA_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= CTRL_RESET;
    end else if (wrOk & isCtrl) begin
      ctrl.ackIntEn <= pwdata[4];
      ctrl.selectIn <= pwdata[3];
      ctrl.init <= pwdata[2];
      ctrl.autoFd <= pwdata[1];
      ctrl.strobe <= pwdata[0];
      if (mode == MODE_BIDIR) begin
        ctrl.dir <= pwdata[5];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      thresh <= THRESH_RESET;
      single_floppy_extension_mode <= 1'b0;
      dataReg <= 8'h00;
    end else begin
      if (wrOk & isLocal) begin
        thresh <= pwdata[3:0];
        single_floppy_extension_mode <= pwdata[LOCAL_SINGLE_FLOPPY_EXTENSION_MODE];
      end
      if (wrOk & isData & (mode != MODE_ECP)) begin
        dataReg <= pwdata[7:0];
      end
    end
  end

  // ***************************************************
  // Shared FIFO
  // ***************************************************
  assign fifoMode = (mode == MODE_FIFO) | (mode == MODE_ECP) |
                    (mode == MODE_TEST);
  assign full = count == FIFO_DEPTH;
  assign empty = count == 5'h0;
  assign freeSlots = FIFO_DEPTH - count;
  assign head = mem[rdPtr];
  assign fwdAuto = ((mode == MODE_ECP) | (mode == MODE_FIFO)) &
                   ~ctrl.dir;
  assign revAuto = (mode == MODE_ECP) & ctrl.dir;
  assign fwdGo = fwdAuto & ~empty & ((mode != MODE_ECP) | pError);

  always_comb begin
    hostPush = wrOk & ((isData & (mode == MODE_ECP)) |
                       (isFifo & fifoMode));
    hostPop = acc & ~pwrite & isFifo & fifoMode;
    dmaPush = dmaAck & dma_enable_bit & fifoMode & ~ctrl.dir & ~hostPush;
    dmaPop = dmaAck & dma_enable_bit & fifoMode & ctrl.dir & ~hostPop;
    engPush = (st == ST_RV_REQ) & ~ackN;
    engPop = (st == ST_IDLE) & fwdGo;
    push = (hostPush | dmaPush | engPush) & ~full;
    pop = (hostPop | dmaPop | engPop) & ~empty;
    pushEntry = '0;
    if (hostPush) begin
      pushEntry.cmd = isData;
      pushEntry.data = pwdata[7:0];
    end else if (dmaPush) begin
      pushEntry.data = dmaWrData;
    end else begin
      pushEntry.cmd = ~busy;
      pushEntry.data = pdIn;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= pushEntry;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= 5'h0;
    end else if (mode == MODE_STD) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= 5'h0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      count <= count + {4'h0, push} - {4'h0, pop};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dmaRdData <= 8'h00;
    end else if (dmaPop & ~empty) begin
      dmaRdData <= head.data;
    end
  end

  // ***************************************************
  // Port handshake engine
  // ***************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= ST_IDLE;
      pdReg <= 8'h00;
      cmdReg <= 1'b0;
    end else if (~(fwdAuto | revAuto)) begin
      st <= ST_IDLE;
    end else begin
      case (st)
        ST_IDLE: begin
          if (fwdGo) begin
            pdReg <= head.data;
            cmdReg <= head.cmd & (mode == MODE_ECP);
            st <= ST_SETUP;
          end else if (revAuto & ~pError & ~full) begin
            st <= ST_RV_REQ;
          end
        end
        ST_SETUP: begin
          if (~busy) begin
            st <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          if (busy) begin
            st <= ST_IDLE;
          end
        end
        ST_RV_REQ: begin
          if (~ackN) begin
            st <= ST_RV_DONE;
          end
        end
        ST_RV_DONE: begin
          if (ackN) begin
            st <= ST_IDLE;
          end
        end
        default: begin
          st <= ST_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    pins.pdOut = fwdAuto ? pdReg : dataReg;
    pins.pdOe = (mode == MODE_STD) |
                (~ctrl.dir & ((mode != MODE_ECP) | pError));
    pins.strobeN = fwdAuto ? (st != ST_STROBE) : ~ctrl.strobe;
    if ((mode == MODE_ECP) & ~ctrl.dir) begin
      pins.autoFdN = ~cmdReg;
    end else if (revAuto) begin
      pins.autoFdN = st != ST_RV_REQ;
    end else begin
      pins.autoFdN = ~ctrl.autoFd;
    end
    pins.initN = (mode == MODE_ECP) ? ~ctrl.dir : ctrl.init;
    pins.selectInN = (mode == MODE_ECP) | ~ctrl.selectIn;
  end

  // ***************************************************
  // Service, DMA and error requests
  // ***************************************************
  // Threshold conditions apply only without DMA, so a DMA run ends
  // solely on terminal count.
  always_comb begin
    if (dma_enable_bit) begin
      svcCond = dmaAck & dmaTc;
    end else if (ctrl.dir) begin
      svcCond = count >= {1'b0, thresh};
    end else begin
      svcCond = freeSlots >= {1'b0, thresh};
    end
  end

  assign svcSet = ~service_interrupt_flag & fifoMode & svcCond;
  assign faultEvt = faultPrev & ~faultN & ~nErrIntrEn &
                    (mode == MODE_ECP) & ~ctrl.dir;
  assign dmaReq = dma_enable_bit & ~service_interrupt_flag & fifoMode &
                  (ctrl.dir ? ~empty : ~full);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      service_interrupt_flag <= 1'b0;
    end else if (svcSet) begin
      service_interrupt_flag <= 1'b1;
    end else if (ecrWr) begin
      service_interrupt_flag <= pwdata[ECR_SVC];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      faultPrev <= 1'b1;
      irqOut <= 1'b0;
    end else begin
      faultPrev <= faultN;
      irqOut <= svcSet | faultEvt;
    end
  end

  // ***************************************************
  // Floppy extension pins
  // ***************************************************
  assign driveBMotorOutN = single_floppy_extension_mode | fdcMotorBN;
  assign driveBSelectOutN = single_floppy_extension_mode | fdcSelectBN;
  assign fdcInN = {diskChangeInN, readDataInN, writeProtectInN,
                   trackZeroInN, indexInN} |
                  ({5{single_floppy_extension_mode}} & pdIn[4:0]);

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence strobeHeld;
    (st == ST_STROBE) && !busy;
  endsequence

  sequence revByteIn;
    (st == ST_RV_REQ) && !ackN && !full;
  endsequence

  a_mode_switch_guard: assert property (
    (mode != $past(mode)) |-> ($past(mode) <= MODE_BIDIR) ||
      (mode <= MODE_BIDIR))
    else $error("illegal mode transition");
  a_dir_only_bidir: assert property (
    (ctrl.dir != $past(ctrl.dir)) |-> $past(mode) == MODE_BIDIR)
    else $error("direction changed outside mode 001");
  a_select_in_ecp: assert property (
    (mode == MODE_ECP) |-> pins.selectInN)
    else $error("nSelectIn asserted in ECP mode");
  a_no_drive_rev: assert property (
    (mode == MODE_ECP && (ctrl.dir || !pError)) |-> !pins.pdOe)
    else $error("data driven while reverse");
  a_strobe_release: assert property (
    strobeHeld ##1 busy |=> pins.strobeN && st == ST_IDLE)
    else $error("strobe not released after busy");
  a_fifo_std_reset: assert property (
    (mode == MODE_STD) |=> empty)
    else $error("FIFO not reset in standard mode");
  a_service_sticky: assert property (
    service_interrupt_flag && !ecrWr |=> service_interrupt_flag)
    else $error("service flag dropped without write");
  a_dma_off_svc: assert property (
    service_interrupt_flag |-> !dmaReq)
    else $error("DMA requested with service flag set");
  a_rev_capture: assert property (
    revByteIn |=> (count == $past(count) + 5'h1 - {4'h0, $past(pop)})
      ##0 pins.autoFdN)
    else $error("reverse byte not stored");
  a_reverse_init: assert property (
    (mode == MODE_ECP) |-> pins.initN == !ctrl.dir)
    else $error("nReverseRequest wrong for direction");

endmodule

// ===== ecppt_periph.sv
// Purpose: Behavioural ECP peripheral facing the parallel port engine.
// Assumes: Pins are sampled on the rising edge of clk.
// Notes: Lag sets how slowly Busy and nAck answer; 0 is prompt.
`timescale 1ns/1ns
module ecppt_periph
  import ecppt_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input ecppt_pins_t pins,
  input wire logic [3:0] lag,
  output logic busy,
  output logic ackN,
  output logic pError,
  output logic [7:0] pdDrive,
  output logic gotValid,
  output logic [8:0] got,
  output logic [7:0] protoErr
);
  // ***************************************************
  // Handshake engine
  // ***************************************************
  logic prevStb;
  logic [7:0] prevPd;
  logic [3:0] waitCnt;
  logic [7:0] revCnt;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      ackN <= 1'b1;
      pError <= 1'b0;
      pdDrive <= 8'h00;
      gotValid <= 1'b0;
      got <= 9'h000;
      protoErr <= 8'h00;
      prevStb <= 1'b1;
      prevPd <= 8'h00;
      waitCnt <= 4'h0;
      revCnt <= 8'h00;
    end else begin
      prevStb <= pins.strobeN;
      prevPd <= pins.pdOut;
      pError <= pins.initN;
      gotValid <= 1'b0;
      if (pins.initN) begin
        if (prevStb && !pins.strobeN) begin
          // A strobe while busy, undriven or with moving data is counted.
          got <= {~pins.autoFdN, pins.pdOut};
          gotValid <= 1'b1;
          if (busy || !pins.pdOe || pins.pdOut !== prevPd) begin
            protoErr <= protoErr + 8'h01;
          end
          waitCnt <= lag;
        end else if (!pins.strobeN && !busy) begin
          if (waitCnt == 4'h0) begin
            busy <= 1'b1;
          end else begin
            waitCnt <= waitCnt - 4'h1;
          end
        end else if (pins.strobeN && busy) begin
          busy <= 1'b0;
        end
      end else if (!pError) begin
        if (!pins.autoFdN && ackN) begin
          // The first byte is a command, whose top bit stays zero.
          pdDrive <= 8'h30 + revCnt;
          busy <= (revCnt != 8'h00);
          if (waitCnt == 4'h0) begin
            ackN <= 1'b0;
          end else begin
            waitCnt <= waitCnt - 4'h1;
          end
        end else if (pins.autoFdN && !ackN) begin
          ackN <= 1'b1;
          revCnt <= revCnt + 8'h01;
          pdDrive <= ~pdDrive;
          waitCnt <= lag;
        end
      end
    end
  end
endmodule

// ===== tb_ecp_parallel_port_transfer.sv
// Purpose: Self-checking bench for the ECP parallel port engine.
// Assumes: Zero wait state APB slave as described in the hand-over.
// Notes: The data wire level is resolved here from both enables.
`timescale 1ns/1ns
module tb_ecp_parallel_port_transfer
  import ecppt_pkg::*;
;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, e;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] pdIn, pdDrive, dmaWrData, dmaRdData, protoErr;
  logic busy, ackN, pError, faultN, dmaReq, dmaAck, dmaTc, irqOut;
  logic fdcMotorBN, fdcSelectBN, driveBMotorOutN, driveBSelectOutN;
  logic gotValid;
  logic [8:0] got;
  logic [4:0] flIn, fdcInN;
  logic [3:0] lag;
  ecppt_pins_t pins;
  int errors, checks_done, irqs, cyc;
  logic [8:0] rxq[$];
  logic [2:0] mlist[6] = '{MODE_BIDIR, MODE_FIFO, MODE_ECP, MODE_EPP,
                           MODE_TEST, MODE_CONFIG};
  logic [8:0] fwd[6] = '{9'h185, 9'h03c, 9'h03d, 9'h070, 9'h071, 9'h072};

  // Lines nobody drives do not keep the peripheral's last byte: the low
  // five float high and the rest show a stale inverse.
  assign pdIn = pins.pdOe ? pins.pdOut :
                (pError ? {~pdDrive[7:5], 5'h1f} : pdDrive);

  ecppt_port dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pdIn(pdIn), .busy(busy), .ackN(ackN), .pError(pError),
    .select(1'b1), .faultN(faultN), .pins(pins), .dmaReq(dmaReq),
    .dmaAck(dmaAck), .dmaTc(dmaTc), .dmaWrData(dmaWrData),
    .dmaRdData(dmaRdData), .irqOut(irqOut), .fdcMotorBN(fdcMotorBN),
    .fdcSelectBN(fdcSelectBN), .diskChangeInN(flIn[4]),
    .readDataInN(flIn[3]), .writeProtectInN(flIn[2]),
    .trackZeroInN(flIn[1]), .indexInN(flIn[0]),
    .driveBMotorOutN(driveBMotorOutN), .driveBSelectOutN(driveBSelectOutN),
    .fdcInN(fdcInN));

  ecppt_periph per (.clk(clk), .sys_rst(sys_rst), .pins(pins), .lag(lag),
    .busy(busy), .ackN(ackN), .pError(pError), .pdDrive(pdDrive),
    .gotValid(gotValid), .got(got), .protoErr(protoErr));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (irqOut === 1'b1) irqs++;
    if (gotValid === 1'b1) rxq.push_back(got);
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end

  // ***************************************************
  // Bus and check tasks
  // ***************************************************
  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input string what, input logic [15:0] a,
                     input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    cmp(what, {24'h0, exp}, r);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    clk = 0;
    sys_rst = 1;
    {psel, penable, pwrite, dmaAck, dmaTc} = '0;
    {paddr, pwdata, dmaWrData} = '0;
    {faultN, fdcMotorBN, fdcSelectBN} = 3'h7;
    flIn = 5'h1f;
    lag = 4'h0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdc("ecr", ADDR_EXTCTRL, 8'h01);
    rdc("dcr", ADDR_CONTROL, 8'hc0);
    rdc("local", ADDR_LOCAL, {4'h0, THRESH_RESET});
    rdc("dsr", ADDR_STATUS, {~busy, ackN, pError, 1'b1, faultN, STATUS_LOW});
    apb(1'b0, 16'h0010, 8'h00);
    cmp("unmapped", 1, 32'(e));
    apb(1'b0, ADDR_CFGB, 8'h00);
    cmp("cfgb err", 1, 32'(e));
    wr(ADDR_EXTCTRL, 8'h08);
    wr(ADDR_FIFO, 8'h55);
    rdc("fifo off", ADDR_EXTCTRL, 8'h09);
    cmp("dmareq off", 0, 32'(dmaReq));
    foreach (mlist[i]) begin
      wr(ADDR_EXTCTRL, {mlist[i], 5'b00100});
      if (mlist[i] == MODE_CONFIG) begin
        rdc("cfga", ADDR_FIFO, CFGA_VALUE);
        rdc("cfgb", ADDR_CFGB, {2'b00, CFGB_LOW});
      end
      wr(ADDR_EXTCTRL, {MODE_FIFO, 5'b00100});
      rdc("mode", ADDR_EXTCTRL, {(mlist[i] <= MODE_BIDIR) ? MODE_FIFO :
          mlist[i], 5'b00101});
      wr(ADDR_EXTCTRL, 8'h04);
    end
    wr(ADDR_CONTROL, 8'h20);
    rdc("dir std", ADDR_CONTROL, 8'hc0);
    wr(ADDR_EXTCTRL, {MODE_TEST, 5'b00100});
    for (int i = 0; i < 17; i++) wr(ADDR_FIFO, 8'(8'ha0 + i));
    rdc("full", ADDR_EXTCTRL, {MODE_TEST, 5'b00110});
    for (int i = 0; i < 16; i++) rdc("test_fifo_port", ADDR_FIFO, 8'(8'ha0 + i));
    rdc("empty", ADDR_EXTCTRL, {MODE_TEST, 5'b00101});
    cmp("test quiet", 0, rxq.size());
    wr(ADDR_EXTCTRL, 8'h04);
    wr(ADDR_CONTROL, 8'h0c);
    lag <= 4'h3;
    wr(ADDR_EXTCTRL, {MODE_ECP, 5'b00000});
    repeat (3) @(posedge clk);
    cmp("pio irq", 1, irqs);
    rdc("svc", ADDR_EXTCTRL, {MODE_ECP, 5'b00101});
    cmp("selectInN", 1, 32'(pins.selectInN));
    cmp("initN fwd", 1, 32'(pins.initN));
    wr(ADDR_DATA, 8'h85);
    wr(ADDR_FIFO, 8'h3c);
    wr(ADDR_FIFO, 8'h3d);
    faultN <= 1'b0;
    repeat (3) @(posedge clk);
    cmp("fault irq", 2, irqs);
    faultN <= 1'b1;
    lag <= 4'h0;
    wr(ADDR_EXTCTRL, {MODE_ECP, 5'b01000});
    for (int i = 0; i < 3; i++) begin
      cmp("dmareq", 1, 32'(dmaReq));
      dmaAck <= 1'b1;
      dmaWrData <= 8'(8'h70 + i);
      dmaTc <= (i == 2);
      @(posedge clk);
      dmaAck <= 1'b0;
      dmaTc <= 1'b0;
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    cmp("dma stop", 0, 32'(dmaReq));
    cmp("tc irq", 3, irqs);
    for (int n = 0; n < 500 && rxq.size() < 6; n++) @(posedge clk);
    cmp("rx count", 6, rxq.size());
    foreach (fwd[i]) cmp("rx", 32'(fwd[i]), 32'(rxq[i]));
    wr(ADDR_EXTCTRL, 8'h04);
    wr(ADDR_EXTCTRL, {MODE_FIFO, 5'b00100});
    wr(ADDR_FIFO, 8'h5a);
    for (int n = 0; n < 100 && rxq.size() < 7; n++) @(posedge clk);
    cmp("fifo mode tx", 32'h05a, 32'(rxq[6]));
    cmp("strobe order", 0, 32'(protoErr));
    wr(ADDR_EXTCTRL, {MODE_BIDIR, 5'b00100});
    wr(ADDR_CONTROL, 8'h20);
    rdc("dir bidir", ADDR_CONTROL, 8'he0);
    wr(ADDR_EXTCTRL, {MODE_ECP, 5'b00100});
    r = '0;
    for (int n = 0; n < 40 && r[1] !== 1'b1; n++) begin
      apb(1'b0, ADDR_EXTCTRL, 8'h00);
    end
    cmp("rev full", {24'h0, MODE_ECP, 5'b00110}, r);
    cmp("initN rev", 0, 32'(pins.initN));
    cmp("pd released", 0, 32'(pins.pdOe));
    for (int i = 0; i < 16; i++) rdc("rev", ADDR_FIFO, 8'(8'h30 + i));
    wr(ADDR_EXTCTRL, {MODE_ECP, 5'b01000});
    cmp("dmareq rev", 1, 32'(dmaReq));
    dmaAck <= 1'b1;
    @(posedge clk);
    dmaAck <= 1'b0;
    @(posedge clk);
    cmp("dma rd", 32'h40, 32'(dmaRdData));
    wr(ADDR_EXTCTRL, {MODE_BIDIR, 5'b00100});
    wr(ADDR_CONTROL, 8'h04);
    wr(ADDR_DATA, 8'h15);
    fdcMotorBN <= 1'b0;
    fdcSelectBN <= 1'b0;
    flIn <= 5'h02;
    wr(ADDR_LOCAL, 8'h18);
    cmp("motorB ext", 1, 32'(driveBMotorOutN));
    cmp("selB ext", 1, 32'(driveBSelectOutN));
    cmp("fdc or", 32'h17, 32'(fdcInN));
    wr(ADDR_LOCAL, 8'h08);
    cmp("motorB", 0, 32'(driveBMotorOutN));
    cmp("fdc plain", 32'h02, 32'(fdcInN));
    results();
  end
endmodule
